// ==== design/pcs_core.sv ====
/*
  Program counter, return stack and indirect address path.
  Assumes the execute logic gives one op per executed instruction, synchronous inputs.
*/
`timescale 1ns/10ps
`include "pcs_defs.svh"

module pcs_core (
  input  wire logic                     clk_i,
  input  wire logic                     reset_n_i,
  input  wire logic [2:0]               op_i,
  input  wire logic [7:0]               low_wdata_i,
  input  wire logic [`PCS_FAR_LO_W-1:0] far_addr_i,
  input  wire logic [`PCS_PC_W-1:0]     vector_i,
  input  wire logic                     latch_we_i,
  input  wire logic [`PCS_LATCH_W-1:0]  latch_wdata_i,
  input  wire logic [7:0]               pointer_i,
  input  wire logic                     indirect_bank_bit_i,
  input  wire logic                     ind_access_i,
  input  wire logic                     ind_we_i,
  input  wire logic [7:0]               mem_rdata_i,
  output logic      [`PCS_PC_W-1:0]     pc_o,
  output logic      [7:0]               counter_low_byte_reg_o,
  output logic      [`PCS_LATCH_W-1:0]  counter_high_latch_o,
  output logic      [`PCS_DADDR_W-1:0]  data_addr_o,
  output logic                          data_we_o,
  output logic      [7:0]               ind_rdata_o
);
  pcs_pkg::pcs_pc_t             pc_q;
  pcs_pkg::pcs_pc_t             pc_d;
  logic [`PCS_LATCH_W-1:0]      latch_q;
  pcs_pkg::pcs_op_t             op;
  logic                         self_sel;

  pcs_stack_if stk ();

  pcs_stack_mem u_stack (
    .clk_i     (clk_i),
    .reset_n_i (reset_n_i),
    .stk       (stk)
  );

  assign op = pcs_pkg::pcs_op_t'(op_i);

  assign stk.push  = (op == pcs_pkg::PCS_OP_CALL) || (op == pcs_pkg::PCS_OP_VECTOR);
  assign stk.pop   = (op == pcs_pkg::PCS_OP_RET);
  assign stk.wdata = pc_q + 13'h0001;

  always_comb begin
    pc_d = pc_q;
    unique case (op)
      pcs_pkg::PCS_OP_STEP:   pc_d = pc_q + 13'h0001;
      // Latch joins the written low byte
      pcs_pkg::PCS_OP_LOW:    pc_d = {latch_q, low_wdata_i};
      pcs_pkg::PCS_OP_FAR:    pc_d = {latch_q[4:3], far_addr_i};
      pcs_pkg::PCS_OP_CALL:   pc_d = {latch_q[4:3], far_addr_i};
      pcs_pkg::PCS_OP_RET:    pc_d = stk.rdata;
      pcs_pkg::PCS_OP_VECTOR: pc_d = vector_i;
      pcs_pkg::PCS_OP_HOLD:   pc_d = pc_q;
      default:                pc_d = pc_q;
    endcase
  end

  // Upper bits from latch on low, far and call ops; step, return and vector take them from elsewhere
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      pc_q <= `PCS_PC_RESET;
    end else begin
      pc_q <= pc_d;
    end
  end

  // Latch touched only by its own write and by reset
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      latch_q <= 5'h00;
    end else if (latch_we_i) begin
      latch_q <= latch_wdata_i;
    end
  end

  assign pc_o                   = pc_q;
  assign counter_low_byte_reg_o = pc_q[7:0];
  assign counter_high_latch_o   = latch_q;

  assign data_addr_o = {indirect_bank_bit_i, pointer_i};
  assign self_sel    = (pointer_i == `PCS_PORT_ADDR);
  assign data_we_o   = ind_access_i && ind_we_i && !self_sel;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      ind_rdata_o <= `PCS_ZERO_BYTE;
    end else if (ind_access_i && !ind_we_i) begin
      ind_rdata_o <= self_sel ? `PCS_ZERO_BYTE : mem_rdata_i;
    end
  end

  a_reset_clear: assert property (@(posedge clk_i)
    !reset_n_i |=> pc_o == 13'h0000)
    else $error("counter not cleared by reset");

  a_low_write_load: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    op == pcs_pkg::PCS_OP_LOW |=> pc_o == {$past(latch_q), $past(low_wdata_i)})
    else $error("low write did not load latch bits");

  a_far_top_bits: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (op == pcs_pkg::PCS_OP_FAR || op == pcs_pkg::PCS_OP_CALL)
    |=> pc_o[12:11] == $past(latch_q[4:3]) && pc_o[10:0] == $past(far_addr_i))
    else $error("far jump top bits wrong");

  a_step_inc: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    op == pcs_pkg::PCS_OP_STEP |=> pc_o == $past(pc_o) + 13'h0001)
    else $error("counter did not step");

  a_call_return: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    op == pcs_pkg::PCS_OP_CALL ##1 op == pcs_pkg::PCS_OP_RET
    |=> pc_o == $past(pc_o, 2) + 13'h0001)
    else $error("return did not restore call address");

  a_latch_kept: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (stk.push || stk.pop) && !latch_we_i |=> $stable(counter_high_latch_o))
    else $error("stack op changed latch");

  a_self_write: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    pointer_i == 8'h00 |-> !data_we_o)
    else $error("write through self pointer");

  a_self_read: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    ind_access_i && !ind_we_i && pointer_i == 8'h00 |=> ind_rdata_o == 8'h00)
    else $error("self pointer read not zero");

  a_ind_addr: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    data_addr_o[8] == indirect_bank_bit_i && data_addr_o[7:0] == pointer_i)
    else $error("indirect address malformed");
endmodule

// ==== design/pcs_defs.svh ====
/*
  Constants for the program counter, return stack and indirect addressing block.
  Assumes inclusion by bare name from the design files.
*/
`ifndef PCS_DEFS_SVH
`define PCS_DEFS_SVH

`define PCS_PC_W        13
`define PCS_PC_RESET    13'h0000
`define PCS_LATCH_W     5
`define PCS_DEPTH       8
`define PCS_PTR_W       3
`define PCS_FAR_LO_W    11
`define PCS_DADDR_W     9
`define PCS_PORT_ADDR   8'h00
`define PCS_ZERO_BYTE   8'h00

`endif

// ==== design/pcs_pkg.sv ====
/*
  Types for the program counter block.
  Assumes the defs header is on the include path.
*/
`include "pcs_defs.svh"

package pcs_pkg;
  typedef logic [`PCS_PC_W-1:0]    pcs_pc_t;
  typedef logic [`PCS_PTR_W-1:0]   pcs_ptr_t;
  typedef logic [`PCS_DADDR_W-1:0] pcs_daddr_t;

  typedef enum logic [2:0] {
    PCS_OP_STEP   = 3'h0,
    PCS_OP_LOW    = 3'h1,
    PCS_OP_FAR    = 3'h2,
    PCS_OP_CALL   = 3'h3,
    PCS_OP_RET    = 3'h4,
    PCS_OP_VECTOR = 3'h5,
    PCS_OP_HOLD   = 3'h6
  } pcs_op_t;
endpackage

// ==== design/pcs_stack_if.sv ====
/*
  Push/pop carrier between the counter logic and the return stack memory.
  Assumes one clock shared by both ends.
*/
`timescale 1ns/10ps
`include "pcs_defs.svh"

interface pcs_stack_if;
  logic            push;
  logic            pop;
  pcs_pkg::pcs_pc_t wdata;
  pcs_pkg::pcs_pc_t rdata;

  modport ctrl (output push, output pop, output wdata, input rdata);
  modport mem  (input push, input pop, input wdata, output rdata);
endinterface

// ==== design/pcs_stack_mem.sv ====
/*
  Eight-entry circular return stack with a hidden pointer.
  Assumes push and pop are never asserted together.
*/
`timescale 1ns/10ps
`include "pcs_defs.svh"

module pcs_stack_mem (
  input  wire logic clk_i,
  input  wire logic reset_n_i,
  pcs_stack_if.mem  stk
);
  pcs_pkg::pcs_pc_t  mem_q [`PCS_DEPTH];
  pcs_pkg::pcs_ptr_t ptr_q;
  pcs_pkg::pcs_ptr_t ptr_dn;

  assign ptr_dn = ptr_q - 3'h1;

  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      ptr_q <= 3'h0;
    end else if (stk.push) begin
      ptr_q <= ptr_q + 3'h1;
    end else if (stk.pop) begin
      ptr_q <= ptr_dn;
    end
  end

  always_ff @(posedge clk_i) begin
    if (stk.push) begin
      mem_q[ptr_q] <= stk.wdata;
    end
  end

  // Top entry combinational so pop lands in one cycle
  assign stk.rdata = mem_q[ptr_dn];

  a_wrap_ptr: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    stk.push |=> ptr_q == $past(ptr_q) + 3'h1)
    else $error("stack pointer did not advance on push");
endmodule

// ==== sim/pcs_mem_model.sv ====
/*
  Data memory stand-in answering indirect reads.
  Assumes a combinational read at the core's address.
*/
`timescale 1ns/10ps
module pcs_mem_model (
  input  wire logic [8:0] addr_i,
  output logic      [7:0] rdata_o
);
  assign rdata_o = addr_i[7:0] ^ {7'h00, addr_i[8]} ^ 8'h5a;
endmodule

// ==== sim/tb.sv ====
/*
  Self-checking bench for the counter, stack and indirect path.
  Assumes one op per executed cycle.
*/
`timescale 1ns/10ps
module tb;
  logic                clk_i, reset_n_i, latch_we_i, indirect_bank_bit_i;
  logic                ind_access_i, ind_we_i, data_we_o;
  logic [2:0]          op_i;
  logic [7:0]          low_wdata_i, pointer_i, mem_rdata_i, counter_low_byte_reg_o, ind_rdata_o;
  logic [10:0]         far_addr_i;
  pcs_pkg::pcs_pc_t    vector_i, pc_o;
  logic [4:0]          latch_wdata_i, counter_high_latch_o;
  pcs_pkg::pcs_daddr_t data_addr_o;
  int                  num_errors, samples_checked;

  pcs_core pcs_core_i (.clk_i, .reset_n_i, .op_i, .low_wdata_i, .far_addr_i, .vector_i,
    .latch_we_i, .latch_wdata_i, .pointer_i, .indirect_bank_bit_i, .ind_access_i, .ind_we_i,
    .mem_rdata_i, .pc_o, .counter_low_byte_reg_o, .counter_high_latch_o, .data_addr_o,
    .data_we_o, .ind_rdata_o);
  pcs_mem_model pcs_mem_model_i (.addr_i(data_addr_o), .rdata_o(mem_rdata_i));

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  task automatic chk(input logic [12:0] seen, input logic [12:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic test_done();
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic go(input logic [2:0] op, input logic [10:0] far);
    @(negedge clk_i);
    op_i = op;
    far_addr_i = far;
    @(negedge clk_i);
    op_i = 3'h6;
  endtask

  task automatic ldl(input logic [4:0] v);
    @(negedge clk_i);
    latch_we_i = 1'b1;
    latch_wdata_i = v;
    @(negedge clk_i);
    latch_we_i = 1'b0;
  endtask

  task automatic t_load();
    chk(pc_o, 13'h0000);
    ldl(5'h12);
    low_wdata_i = 8'h34;
    go(3'h1, 11'h000);
    chk(pc_o, 13'h1234);
    chk(counter_low_byte_reg_o, 8'h34);
    go(3'h0, 11'h000);
    chk(pc_o, 13'h1235);
    ldl(5'h1f);
    low_wdata_i = 8'hff;
    go(3'h1, 11'h000);
    go(3'h0, 11'h000);
    chk(pc_o, 13'h0000);
    chk(counter_high_latch_o, 5'h1f);
    go(3'h2, 11'h123);
    chk(pc_o, 13'h1923);
  endtask

  task automatic t_reset_mid();
    @(negedge clk_i);
    reset_n_i = 1'b0;
    @(negedge clk_i);
    reset_n_i = 1'b1;
    chk(pc_o, 13'h0000);
    chk(counter_high_latch_o, 5'h00);
  endtask

  task automatic t_stack();
    ldl(5'h07);
    go(3'h2, 11'h000);
    for (int i = 1; i <= 9; i++) begin
      go(3'h3, i[10:0]);
      chk(pc_o, i[12:0]);
    end
    for (int j = 9; j >= 2; j--) begin
      go(3'h4, 11'h000);
      chk(pc_o, j[12:0]);
    end
    go(3'h4, 11'h000);
    chk(pc_o, 13'h0009);
    chk(counter_high_latch_o, 5'h07);
    vector_i = 13'h0004;
    go(3'h5, 11'h000);
    chk(pc_o, 13'h0004);
    go(3'h4, 11'h000);
    chk(pc_o, 13'h000a);
  endtask

  task automatic t_ind();
    @(negedge clk_i);
    ind_access_i = 1'b1;
    ind_we_i = 1'b1;
    pointer_i = 8'h45;
    indirect_bank_bit_i = 1'b1;
    #1 chk(data_addr_o, 9'h145);
    chk(data_we_o, 1'b1);
    pointer_i = 8'h00;
    #1 chk(data_we_o, 1'b0);
    ind_we_i = 1'b0;
    @(negedge clk_i);
    chk(ind_rdata_o, 8'h00);
    pointer_i = 8'h45;
    @(negedge clk_i);
    chk(ind_rdata_o, 8'h1e);
    ind_access_i = 1'b0;
  endtask

  initial begin
    repeat (2000) @(posedge clk_i);
    num_errors++;
    test_done();
  end

  initial begin
    {reset_n_i, latch_we_i, indirect_bank_bit_i, ind_access_i, ind_we_i} = 5'h00;
    op_i = 3'h6;
    {low_wdata_i, pointer_i, far_addr_i, vector_i, latch_wdata_i} = 45'h0;
    repeat (8) @(posedge clk_i);
    @(negedge clk_i);
    reset_n_i = 1'b1;
    t_load();
    t_stack();
    t_reset_mid();
    t_ind();
    test_done();
  end
endmodule
